// File: rtl/cvs_pkg.sv
// Constants for the coil-voltage 270 degree result and low limit B registers.
// Assumes a 16-bit register word with the frame parity in bit 0.
package cvs_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned          ADDR_W          = 6;
    localparam int unsigned          WORD_W          = 16;
    localparam int unsigned          CV_W            = 10;
    localparam int unsigned          PHASE_W         = 6;
    localparam logic [ADDR_W-1:0]    ADDR_CV_270     = 6'h0c;
    localparam logic [ADDR_W-1:0]    ADDR_LOW_LIM_B  = 6'h0d;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int unsigned          FIELD_LSB       = 1;
    localparam int unsigned          FIELD_MSB       = 10;
    localparam int unsigned          RSVD_LSB        = 11;
    localparam int unsigned          RSVD_MSB        = 15;
    localparam int unsigned          PARITY_BIT      = 0;
    localparam logic [4:0]           RSVD_VALUE      = 5'h00;
    localparam logic [CV_W-1:0]      CV_RESET        = 10'h000;
    localparam logic [CV_W-1:0]      THR_RESET       = 10'h000;

    // ------------------------------------------------------------------
    // Measurement
    // ------------------------------------------------------------------
    localparam logic [PHASE_W-1:0]   PHASE_270       = 6'h30;
    localparam int unsigned          VS_FULL_SCALE_MV = 28000;

    typedef enum logic [1:0] {
        CVS_RD_IDLE,
        CVS_RD_ANSWER
    } cvs_rd_state_t;

endpackage : cvs_pkg

// File: rtl/cvs_parity.sv
// Odd-parity generator and checker for one 16-bit register word.
// Assumes parity sits in bit 0 and covers bits 15 down to 1.
`timescale 1ns/1ns
`default_nettype none

module cvs_parity
    import cvs_pkg::*;
(
    input  wire logic [WORD_W-1:0] i_word,
    output logic                   o_parity,
    output logic                   o_ok
);

    // ------------------------------------------------------------------
    // Odd parity: an all-zero word carries a one in bit 0
    // ------------------------------------------------------------------
    assign o_parity = ~(^i_word[WORD_W-1:FIELD_LSB]);
    assign o_ok     = (i_word[PARITY_BIT] == o_parity);

endmodule // cvs_parity

`default_nettype wire

// File: rtl/cvs_regs.sv
// Coil-voltage 270 degree result register and low limit B comparator.
// Assumes the frame logic presents decoded register accesses synchronous to i_core_clk
// and the ADC path presents one averaged 10-bit code per micro-step.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Result register at address 0x0C is read only; bits 15..11 read zero.
// - 10-bit 270 degree coil voltage sits in bits 10..1, resets to zero.
// - Result loads the averaged measurement taken when phase counter equals 48.
// - Coil voltage code full scale corresponds to the 28 V supply maximum.
// - Low limit B register at 0x0D; bits 15..11 read zero, 10..1 writable.
// - 10-bit writable threshold B in bits 10..1, reset to zero.
// - Each measurement sets below-threshold flag if under threshold B, else clears it.
module cvs_regs
    import cvs_pkg::*;
(
    input  wire logic               i_core_clk,
    input  wire logic               i_sys_rst,
    input  wire logic [ADDR_W-1:0]  i_reg_addr,
    input  wire logic               i_reg_wr,
    input  wire logic               i_reg_rd,
    input  wire logic [WORD_W-1:0]  i_reg_wdata,
    input  wire logic               i_meas_valid,
    input  wire logic [CV_W-1:0]    i_meas_value,
    input  wire logic [PHASE_W-1:0] i_phase_cnt,
    output logic [WORD_W-1:0]       o_reg_rdata,
    output logic                    o_reg_rd_valid,
    output logic                    o_parity_err,
    output logic [CV_W-1:0]         o_coil_voltage_270,
    output logic                    o_below_threshold_b_flag
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [CV_W-1:0]   cv_270_q;
    logic [CV_W-1:0]   cv_270_d;
    logic [CV_W-1:0]   thr_b_q;
    logic [CV_W-1:0]   thr_b_d;
    logic              flag_q;
    logic              flag_d;
    logic [WORD_W-1:0] rdata_q;
    logic [WORD_W-1:0] rdata_d;
    logic              perr_q;
    cvs_rd_state_t     rd_state_q;
    cvs_rd_state_t     rd_state_d;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic logic [WORD_W-1:0] pack_word(input logic [CV_W-1:0] val);
        logic [WORD_W-1:0] w;
        w                     = '0;
        w[RSVD_MSB:RSVD_LSB]  = RSVD_VALUE;
        w[FIELD_MSB:FIELD_LSB] = val;
        return w;
    endfunction

    wire               sel_cv_270;
    wire               sel_thr_b;
    wire               wr_par_ok;
    wire               wr_thr_b;
    wire               meas_270;
    wire               meas_below;
    wire               rd_par;
    wire [WORD_W-1:0]  rd_word;

    assign sel_cv_270 = (i_reg_addr == ADDR_CV_270);
    assign sel_thr_b  = (i_reg_addr == ADDR_LOW_LIM_B);
    // Parity-bad writes are dropped so a corrupted frame never moves the threshold
    assign wr_thr_b   = i_reg_wr && sel_thr_b && wr_par_ok;
    assign meas_270   = i_meas_valid && (i_phase_cnt == PHASE_270);
    assign meas_below = i_meas_value < thr_b_q;

    // Unmapped addresses answer an all-zero field
    assign rd_word = sel_cv_270 ? pack_word(cv_270_q) :
                     sel_thr_b  ? pack_word(thr_b_q)  :
                                  pack_word(CV_RESET);

    cvs_parity u_wr_par (
        .i_word   (i_reg_wdata),
        .o_parity (),
        .o_ok     (wr_par_ok)
    );

    cvs_parity u_rd_par (
        .i_word   (rd_word),
        .o_parity (rd_par),
        .o_ok     ()
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Code is taken as delivered: full scale already means the 28 V maximum
    assign cv_270_d = meas_270 ? i_meas_value : cv_270_q;
    assign thr_b_d  = wr_thr_b ? i_reg_wdata[FIELD_MSB:FIELD_LSB] : thr_b_q;
    // Flag follows every measurement, not only phase 48, so a sag anywhere in the step is seen
    assign flag_d   = i_meas_valid ? meas_below : flag_q;
    assign rdata_d  = i_reg_rd ? {rd_word[WORD_W-1:FIELD_LSB], rd_par} : rdata_q;

    // The answer strobe trails the read strobe by one cycle; back-to-back reads keep it high
    // A read in the same cycle as a write returns the value from before the write
    always_comb begin
        case (rd_state_q)
            CVS_RD_IDLE:   rd_state_d = i_reg_rd ? CVS_RD_ANSWER : CVS_RD_IDLE;
            CVS_RD_ANSWER: rd_state_d = i_reg_rd ? CVS_RD_ANSWER : CVS_RD_IDLE;
            default:       rd_state_d = CVS_RD_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cv_270_q   <= CV_RESET;
            thr_b_q    <= THR_RESET;
            flag_q     <= 1'b0;
            rdata_q    <= '0;
            perr_q     <= 1'b0;
            rd_state_q <= CVS_RD_IDLE;
        end else begin
            cv_270_q   <= cv_270_d;
            thr_b_q    <= thr_b_d;
            flag_q     <= flag_d;
            rdata_q    <= rdata_d;
            perr_q     <= i_reg_wr && !wr_par_ok;
            rd_state_q <= rd_state_d;
        end
    end

    assign o_reg_rdata              = rdata_q;
    assign o_reg_rd_valid           = (rd_state_q == CVS_RD_ANSWER);
    assign o_parity_err             = perr_q;
    assign o_coil_voltage_270       = cv_270_q;
    assign o_below_threshold_b_flag = flag_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    chk_result_load: assert property (
        meas_270 |=> cv_270_q == $past(i_meas_value))
        else $error("270 result not loaded at phase 48");

    chk_result_hold: assert property (
        !meas_270 |=> $stable(cv_270_q))
        else $error("270 result changed outside phase 48");

    chk_result_ro: assert property (
        i_reg_wr && sel_cv_270 && !meas_270 |=> $stable(cv_270_q))
        else $error("write reached read-only result");

    chk_rd_reserved: assert property (
        o_reg_rd_valid |-> o_reg_rdata[RSVD_MSB:RSVD_LSB] == RSVD_VALUE)
        else $error("reserved bits read non-zero");

    chk_rd_result: assert property (
        i_reg_rd && sel_cv_270 |=> o_reg_rd_valid && o_reg_rdata[FIELD_MSB:FIELD_LSB] == $past(cv_270_q))
        else $error("result read data wrong");

    chk_thr_write: assert property (
        wr_thr_b ##1 i_reg_rd && sel_thr_b |=> o_reg_rdata[FIELD_MSB:FIELD_LSB] == $past(i_reg_wdata[FIELD_MSB:FIELD_LSB], 2))
        else $error("threshold B write not read back");

    chk_flag_below: assert property (
        i_meas_valid && (i_meas_value < thr_b_q) |=> o_below_threshold_b_flag)
        else $error("flag not set below threshold");

    chk_flag_clear: assert property (
        i_meas_valid && (i_meas_value >= thr_b_q) |=> !o_below_threshold_b_flag)
        else $error("flag not cleared at or above threshold");

    chk_rd_parity: assert property (
        o_reg_rd_valid |-> ^o_reg_rdata == 1'b1)
        else $error("read word parity not odd");

    chk_bad_write: assert property (
        i_reg_wr && !wr_par_ok |=> o_parity_err && $stable(thr_b_q))
        else $error("parity-bad write not refused");

    chk_good_write: assert property (
        !(i_reg_wr && !wr_par_ok) |=> !o_parity_err)
        else $error("parity error without a bad write");

    chk_thr_hold: assert property (
        !wr_thr_b |=> $stable(thr_b_q))
        else $error("threshold B changed without a write");

    chk_rd_thr: assert property (
        i_reg_rd && sel_thr_b |=> o_reg_rdata[FIELD_MSB:FIELD_LSB] == $past(thr_b_q))
        else $error("threshold B read data wrong");

    chk_flag_hold: assert property (
        !i_meas_valid |=> $stable(o_below_threshold_b_flag))
        else $error("flag changed without a measurement");

    chk_rd_answer: assert property (
        o_reg_rd_valid == $past(i_reg_rd))
        else $error("read answer strobe out of step");

    chk_rd_hold: assert property (
        !i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data changed without a read");

    // ------------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------------
    cov_load_270:  cover property (meas_270 ##[1:4] i_reg_rd && sel_cv_270);
    cov_flag_set:  cover property (wr_thr_b ##[1:4] i_meas_valid && meas_below);
    cov_bad_write: cover property (i_reg_wr && sel_thr_b && !wr_par_ok);
    cov_wr_rd_thr: cover property (wr_thr_b ##1 i_reg_rd && sel_thr_b);
    cov_unmapped:  cover property (i_reg_rd && !sel_cv_270 && !sel_thr_b);

endmodule // cvs_regs

`default_nettype wire

// File: verif/cvs_host_model.sv
// Host-side model: issues register reads and writes, adding frame parity.
// Assumes the device takes strobes on the rising edge of i_core_clk.
`timescale 1ns/1ns
`default_nettype none

module cvs_host_model
    import cvs_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic [WORD_W-1:0] i_rdata,
    input  wire logic              i_rd_valid,
    output logic [ADDR_W-1:0]      o_addr,
    output logic                   o_wr,
    output logic                   o_rd,
    output logic [WORD_W-1:0]      o_wdata
);
    // ------------------------------------------------------------------
    // Bus access
    // ------------------------------------------------------------------
    initial begin
        o_addr  = '0;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = '0;
    end

    // Bad parity only when a scenario asks for a refused write
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] w, input logic bad);
        @(posedge i_core_clk);
        #1;
        o_addr  = a;
        o_wdata = {w[15:1], (~^w[15:1]) ^ bad};
        o_wr    = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_wr    = 1'b0;
        // Released lines show the inverse so stale values never look valid
        o_addr  = ~a;
        o_wdata = ~o_wdata;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] w, output logic v);
        @(posedge i_core_clk);
        #1;
        o_addr = a;
        o_rd   = 1'b1;
        @(posedge i_core_clk);
        #1;
        w      = i_rdata;
        v      = i_rd_valid;
        o_rd   = 1'b0;
        o_addr = ~a;
    endtask

    // Write on one edge and read the same register on the next one
    task automatic wrrd(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] w, output logic [WORD_W-1:0] r,
                        output logic v);
        @(posedge i_core_clk);
        #1;
        o_addr  = a;
        o_wdata = {w[15:1], ~^w[15:1]};
        o_wr    = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_wr    = 1'b0;
        o_rd    = 1'b1;
        @(posedge i_core_clk);
        #1;
        r       = i_rdata;
        v       = i_rd_valid;
        o_rd    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~o_wdata;
    endtask
endmodule // cvs_host_model

`default_nettype wire

// File: verif/coil_voltage_270_and_low_limit_b_test.sv
// Self-checking bench for the coil-voltage result and low limit B registers.
// Assumes cvs_regs as device and cvs_host_model as register host.
`timescale 1ns/1ns
`default_nettype none

module coil_voltage_270_and_low_limit_b_test;
    import cvs_pkg::*;
    logic              clk;
    logic              rst;
    logic              mv;
    logic [CV_W-1:0]   mval;
    logic [PHASE_W-1:0] ph;
    wire logic [ADDR_W-1:0] addr;
    wire logic         wr;
    wire logic         rd;
    wire logic [WORD_W-1:0] wdata;
    logic [WORD_W-1:0] rdata;
    logic              rvld;
    logic              perr;
    logic [CV_W-1:0]   cv270;
    logic              flag;
    logic [WORD_W-1:0] w;
    logic              v;
    int                miscompares;
    int                total_checks;
    int                cyc;

    cvs_regs uut (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .i_meas_valid(mv), .i_meas_value(mval), .i_phase_cnt(ph), .o_reg_rdata(rdata),
        .o_reg_rd_valid(rvld), .o_parity_err(perr), .o_coil_voltage_270(cv270), .o_below_threshold_b_flag(flag));
    cvs_host_model host (.i_core_clk(clk), .i_rdata(rdata), .i_rd_valid(rvld), .o_addr(addr), .o_wr(wr),
        .o_rd(rd), .o_wdata(wdata));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] ew(input logic [9:0] f);
        return {5'h00, f, ~^f};
    endfunction

    task automatic rdchk(input logic [5:0] a, input logic [15:0] exp);
        host.rd(a, w, v);
        chk({15'h0, v}, 16'h0001);
        chk(w, exp);
    endtask

    // Measurement pulse; outputs are settled when this returns
    task automatic meas(input logic [9:0] val, input logic [5:0] p);
        @(posedge clk);
        #1;
        mv   = 1'b1;
        mval = val;
        ph   = p;
        @(posedge clk);
        #1;
        mv   = 1'b0;
        mval = ~val;
        ph   = ~p;
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rdchk(ADDR_CV_270, 16'h0001);
        rdchk(ADDR_LOW_LIM_B, 16'h0001);
        chk({15'h0, flag}, 16'h0000);
    endtask

    task automatic t_thr();
        host.wrrd(ADDR_LOW_LIM_B, {5'h00, 10'h0aa, 1'b0}, w, v);
        chk({15'h0, v}, 16'h0001);
        chk(w, ew(10'h0aa));
        host.wr(ADDR_LOW_LIM_B, {5'h1f, 10'h155, 1'b0}, 1'b0);
        chk({15'h0, perr}, 16'h0000);
        rdchk(ADDR_LOW_LIM_B, ew(10'h155));
        host.wr(ADDR_LOW_LIM_B, {5'h00, 10'h2aa, 1'b0}, 1'b1);
        chk({15'h0, perr}, 16'h0001);
        rdchk(ADDR_LOW_LIM_B, ew(10'h155));
        host.wr(ADDR_CV_270, 16'hfffe, 1'b0);
        rdchk(ADDR_CV_270, 16'h0001);
        rdchk(6'h3f, 16'h0001);
    endtask

    task automatic t_meas();
        meas(10'h154, PHASE_270);
        chk({6'h0, cv270}, 16'h0154);
        chk({15'h0, flag}, 16'h0001);
        meas(10'h155, 6'h2f);
        chk({6'h0, cv270}, 16'h0154);
        chk({15'h0, flag}, 16'h0000);
        meas(10'h3ff, PHASE_270);
        rdchk(ADDR_CV_270, ew(10'h3ff));
    endtask

    // ------------------------------------------------------------------
    // Clock, reset, run
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Whole run needs about 40 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            miscompares++;
            give_verdict();
        end
    end

    initial begin
        rst  = 1'b1;
        mv   = 1'b0;
        mval = '0;
        ph   = '0;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_thr();
        t_meas();
        give_verdict();
    end
endmodule // coil_voltage_270_and_low_limit_b_test

`default_nettype wire
